// [design/psbp_pkg.sv]
// Shared constants, types and line-order functions for the peripheral select bus
package psbp_pkg;
    localparam int BYTE_W = 8;
    localparam int PA_W = 13;
    localparam int INSTR_W = 16;
    localparam int QTR_W = 2;
    // One instruction cycle is four quarters of sys_clk
    localparam logic [QTR_W-1:0] QTR_FIRST = 2'h0;
    localparam logic [QTR_W-1:0] QTR_DRIVE = 2'h1;
    localparam logic [QTR_W-1:0] QTR_MCLK = 2'h2;
    localparam logic [QTR_W-1:0] QTR_LAST = 2'h3;
    localparam logic [QTR_W-1:0] QTR_STEP = 2'h1;
    localparam logic [PA_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PA_W-1:0] PC_STEP = 13'h0001;
    localparam logic [INSTR_W-1:0] IR_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    // Undriven lines float high, which reads as logical zero
    localparam logic [BYTE_W-1:0] BUS_IDLE = 8'hFF;
    // Instruction word fields, logical bit numbering
    localparam int KIND_HI = 15;
    localparam int KIND_LO = 14;
    localparam int LEFT_BIT = 13;
    localparam int RIGHT_BIT = 12;
    localparam int IMM_HI = 7;
    localparam int IMM_LO = 0;
    typedef enum logic [1:0] {
        PSBP_NOP = 2'h0,
        PSBP_SELECT = 2'h1,
        PSBP_WRITE = 2'h2,
        PSBP_READ = 2'h3
    } psbp_kind_t;

    // Line 7 carries the LSB and a low level is a one
    function automatic logic [BYTE_W-1:0] bus_code(input logic [BYTE_W-1:0] b);
        logic [BYTE_W-1:0] r;
        r = BYTE_ZERO;
        for (int i = 0; i < BYTE_W; i++) begin
            r[i] = ~b[BYTE_W-1-i];
        end
        return r;
    endfunction

    function automatic logic [PA_W-1:0] rev_addr(input logic [PA_W-1:0] a);
        logic [PA_W-1:0] r;
        r = PC_RESET;
        for (int i = 0; i < PA_W; i++) begin
            r[i] = a[PA_W-1-i];
        end
        return r;
    endfunction

    function automatic logic [INSTR_W-1:0] rev_instr(input logic [INSTR_W-1:0] a);
        logic [INSTR_W-1:0] r;
        r = IR_RESET;
        for (int i = 0; i < INSTR_W; i++) begin
            r[i] = a[INSTR_W-1-i];
        end
        return r;
    endfunction
endpackage

// [design/psbp_if.sv]
// Bus wiring between the controller and its I/O ports
`timescale 1ns/1ns
`default_nettype none
interface psbp_if
    import psbp_pkg::*;
#(
    parameter int NUM_PORTS = 2
)();
    logic address_select_strobe;
    logic write_direction_strobe;
    logic left_bank_enable_n;
    logic right_bank_enable_n;
    logic master_clock;
    logic [BYTE_W-1:0] ctrl_bus_out;
    logic ctrl_bus_oe;
    logic [BYTE_W-1:0] port_bus_out [NUM_PORTS];
    logic port_bus_oe [NUM_PORTS];
    logic [BYTE_W-1:0] port_bus_lines;

    // Pulled-up lines: any driver pulling low wins
    always_comb begin
        port_bus_lines = BUS_IDLE;
        if (ctrl_bus_oe) begin
            port_bus_lines = port_bus_lines & ctrl_bus_out;
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_bus_oe[i]) begin
                port_bus_lines = port_bus_lines & port_bus_out[i];
            end
        end
    end

    modport ctrl (
        output address_select_strobe,
        output write_direction_strobe,
        output left_bank_enable_n,
        output right_bank_enable_n,
        output master_clock,
        output ctrl_bus_out,
        output ctrl_bus_oe,
        input port_bus_lines
    );
    modport port (
        input address_select_strobe,
        input write_direction_strobe,
        input left_bank_enable_n,
        input right_bank_enable_n,
        input master_clock,
        output port_bus_out,
        output port_bus_oe,
        input port_bus_lines
    );
endinterface
`default_nettype wire

// [design/psbp_port_sel.sv]
// Select latch for one I/O port
`timescale 1ns/1ns
`default_nettype none
module psbp_port_sel
    import psbp_pkg::*;
#(
    parameter logic [BYTE_W-1:0] PORT_ADDR = 8'h00
)(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic select_cycle,
    input wire logic [BYTE_W-1:0] bus_addr,
    output logic selected
);
    wire addr_hit = (bus_addr == PORT_ADDR);

    // Selection holds until a select cycle on this bank names another address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            selected <= 1'b0;
        end else if (select_cycle) begin
            selected <= addr_hit;
        end
    end
endmodule // psbp_port_sel
`default_nettype wire

// [design/psbp_port.sv]
// I/O port end of the peripheral select bus
`timescale 1ns/1ns
`default_nettype none
module psbp_port
    import psbp_pkg::*;
#(
    parameter int NUM_PORTS = 2,
    parameter int PORT_INDEX = 0,
    parameter logic [BYTE_W-1:0] PORT_ADDR = 8'h00,
    parameter bit RIGHT_BANK = 1'b0,
    parameter bit SNOOP_READS = 1'b0
)(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [BYTE_W-1:0] supply_byte,
    output logic [BYTE_W-1:0] taken_byte,
    output logic taken_valid,
    output logic supply_served,
    output logic selected,
    psbp_if.port bus
);
    if (PORT_INDEX < 0 || PORT_INDEX >= NUM_PORTS) begin : g_bad_index
        $error("PORT_INDEX outside interface range");
    end

    logic drive_oe;
    logic [BYTE_W-1:0] drive_byte;
    wire bank_low = RIGHT_BANK ? !bus.right_bank_enable_n : !bus.left_bank_enable_n;
    wire [BYTE_W-1:0] bus_byte = bus_code(bus.port_bus_lines);
    wire select_cycle = bus.master_clock && bus.address_select_strobe && bank_low;
    wire data_cycle = selected && bank_low && !bus.address_select_strobe;
    wire next_drive = data_cycle && !bus.write_direction_strobe && !SNOOP_READS;
    wire capture = bus.master_clock && data_cycle
                   && (bus.write_direction_strobe || SNOOP_READS);

    psbp_port_sel #(
        .PORT_ADDR(PORT_ADDR)
    ) u_sel (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .select_cycle(select_cycle),
        .bus_addr(bus_byte),
        .selected(selected)
    );

    assign bus.port_bus_out[PORT_INDEX] = drive_byte;
    assign bus.port_bus_oe[PORT_INDEX] = drive_oe;

    // Drive is registered, so it releases one clock after the strobes change
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_oe <= 1'b0;
            drive_byte <= BUS_IDLE;
        end else begin
            drive_oe <= next_drive;
            drive_byte <= bus_code(supply_byte);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            taken_byte <= BYTE_ZERO;
            taken_valid <= 1'b0;
            supply_served <= 1'b0;
        end else begin
            taken_valid <= capture;
            supply_served <= bus.master_clock && drive_oe && data_cycle;
            if (capture) begin
                taken_byte <= bus_byte;
            end
        end
    end
endmodule // psbp_port
`default_nettype wire

// [design/psbp_ctrl.sv]
// Controller end of the peripheral select bus
// Functional notes
// - Select: address on bus, select strobe high
// - Port stays selected until another address
// - Write strobe high whole cycle, controller drives from quarter 1
// - Data cycles use the latest selected port
// - Bank enables active low, gate port response
// - Opposite banks may share one address
// - Both banks: port to port in one cycle
// - Bank enables with strobes, from instruction fields
// - Bus negative logic, line 7 is LSB
// - Active-high master clock times port accesses
// - Reset clears counter, stops clock, banks high
// - Halt stops at next instruction, banks high
// - Thirteen address lines, line 12 is LSB
// - Sixteen instruction lines, line 15 is LSB
// - Ports decode, follow direction, bank, data
`timescale 1ns/1ns
`default_nettype none
module psbp_ctrl
    import psbp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic halt_n,
    output logic [PA_W-1:0] program_address_lines,
    input wire logic [INSTR_W-1:0] instruction_lines,
    output logic [BYTE_W-1:0] read_data,
    output logic read_valid,
    output logic halted,
    psbp_if.ctrl bus
);
    typedef enum logic {
        PSBP_RUN,
        PSBP_HALT
    } psbp_state_t;

    // The quarter plan only works in this order: banks, drive, master clock, fetch
    if (!(QTR_FIRST < QTR_DRIVE && QTR_DRIVE < QTR_MCLK && QTR_MCLK < QTR_LAST)) begin : g_bad_quarters
        $error("Quarter plan out of order");
    end
    if (QTR_LAST != (1 << QTR_W) - 1) begin : g_bad_wrap
        $error("Quarter counter must wrap after the last quarter");
    end
    if (PC_STEP == '0) begin : g_bad_step
        $error("Program counter step must not be zero");
    end
    if (IMM_HI - IMM_LO + 1 != BYTE_W) begin : g_bad_imm
        $error("Immediate field must fill one bus byte");
    end
    if (KIND_HI != INSTR_W - 1 || KIND_HI - KIND_LO != 1) begin : g_bad_kind
        $error("Kind field must be the top two instruction bits");
    end
    if (LEFT_BIT >= KIND_LO || RIGHT_BIT >= LEFT_BIT || IMM_HI >= RIGHT_BIT) begin : g_bad_fields
        $error("Instruction fields overlap");
    end

    // Fetch and execute both split the same kind field
    function automatic logic [1:0] kind_of(input logic [INSTR_W-1:0] w);
        return w[KIND_HI:KIND_LO];
    endfunction

    psbp_state_t state;
    psbp_state_t next_state;
    logic [QTR_W-1:0] qtr;
    logic [PA_W-1:0] pc;
    logic [INSTR_W-1:0] ir;
    logic sc;
    logic wc;
    logic left_n;
    logic right_n;
    logic mclk;
    logic bus_oe;
    logic [BYTE_W-1:0] bus_out;

    // Quarter sequencing
    wire [QTR_W-1:0] next_qtr = qtr + QTR_STEP;
    wire cycle_end = (qtr == QTR_LAST);
    wire drive_edge = (qtr == QTR_FIRST);
    wire sample_edge = (qtr == QTR_MCLK);

    // Fetch decode: the word on the lines becomes the next instruction
    wire [INSTR_W-1:0] fetched = rev_instr(instruction_lines);
    wire fetch_ok = halt_n;
    wire [1:0] fetch_kind_bits = kind_of(fetched);
    wire fetch_left = fetched[LEFT_BIT];
    wire fetch_right = fetched[RIGHT_BIT];
    wire fetch_select = fetch_ok && (fetch_kind_bits == PSBP_SELECT);
    wire fetch_write = fetch_ok && (fetch_kind_bits == PSBP_WRITE);
    wire fetch_take = cycle_end && fetch_ok;
    // A refused fetch leaves every strobe idle and both banks high
    wire next_sc = fetch_select;
    wire next_wc = fetch_write;
    wire next_left_n = !(fetch_ok && fetch_left);
    wire next_right_n = !(fetch_ok && fetch_right);

    // Current instruction decode
    wire [1:0] ir_kind_bits = kind_of(ir);
    wire [BYTE_W-1:0] ir_imm = ir[IMM_HI:IMM_LO];
    wire running = (state == PSBP_RUN);
    wire ir_drives = running && ((ir_kind_bits == PSBP_SELECT) || (ir_kind_bits == PSBP_WRITE));
    wire ir_reads = running && (ir_kind_bits == PSBP_READ);
    wire [PA_W-1:0] next_pc = pc + PC_STEP;
    wire next_mclk = (next_qtr == QTR_MCLK);
    wire [PA_W-1:0] next_pa_lines = rev_addr(next_pc);
    wire [BYTE_W-1:0] next_bus_out = bus_code(ir_imm);
    wire take_read = sample_edge && ir_reads;
    wire [BYTE_W-1:0] bus_value = bus_code(bus.port_bus_lines);

    // Halt is looked at only on the fetch edge, so a pulse inside a cycle is missed
    always_comb begin
        next_state = state;
        if (cycle_end) begin
            next_state = fetch_ok ? PSBP_RUN : PSBP_HALT;
        end
    end

    // Master clock keeps running while halted; reset holds it low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            qtr <= QTR_FIRST;
            mclk <= 1'b0;
        end else begin
            qtr <= next_qtr;
            mclk <= next_mclk;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= PSBP_RUN;
            halted <= 1'b0;
        end else begin
            state <= next_state;
            halted <= (next_state == PSBP_HALT);
        end
    end

    // Counter and instruction advance only on a taken fetch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= PC_RESET;
            ir <= IR_RESET;
        end else if (fetch_take) begin
            pc <= next_pc;
            ir <= fetched;
        end
    end

    // The address register has its own flops so the pins never wait on the reversal
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            program_address_lines <= PC_RESET;
        end else if (fetch_take) begin
            program_address_lines <= next_pa_lines;
        end
    end

    // Strobes and banks change together at the instruction boundary
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sc <= 1'b0;
            wc <= 1'b0;
            left_n <= 1'b1;
            right_n <= 1'b1;
        end else if (cycle_end) begin
            sc <= next_sc;
            wc <= next_wc;
            left_n <= next_left_n;
            right_n <= next_right_n;
        end
    end

    // Drive starts a quarter late so a port's registered release cannot overlap
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_oe <= 1'b0;
            bus_out <= BUS_IDLE;
        end else if (drive_edge) begin
            bus_oe <= ir_drives;
            bus_out <= next_bus_out;
        end else if (cycle_end) begin
            bus_oe <= 1'b0;
            bus_out <= BUS_IDLE;
        end
    end

    // Read data is taken while the master clock is high
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= BYTE_ZERO;
            read_valid <= 1'b0;
        end else begin
            read_valid <= take_read;
            if (take_read) begin
                read_data <= bus_value;
            end
        end
    end

    // Every bus control comes straight from a flop, so ports see no decode glitches
    assign bus.address_select_strobe = sc;
    assign bus.write_direction_strobe = wc;
    assign bus.left_bank_enable_n = left_n;
    assign bus.right_bank_enable_n = right_n;
    assign bus.master_clock = mclk;
    assign bus.ctrl_bus_out = bus_out;
    assign bus.ctrl_bus_oe = bus_oe;
endmodule // psbp_ctrl
`default_nettype wire

// [tb/psbp_bus_monitor.sv]
// Concurrent checks on the wires between controller and ports
`timescale 1ns/1ns
`default_nettype none
module psbp_bus_monitor
    import psbp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic address_select_strobe,
    input wire logic write_direction_strobe,
    input wire logic left_bank_enable_n,
    input wire logic right_bank_enable_n,
    input wire logic master_clock,
    input wire logic [BYTE_W-1:0] ctrl_bus_out,
    input wire logic ctrl_bus_oe,
    input wire logic [BYTE_W-1:0] port_bus_lines
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_mclk_period: assert property (master_clock |=> !master_clock [*3] ##1 master_clock)
        else $error("master clock pulse or period off");
    chk_select_drive: assert property (address_select_strobe && master_clock
        |-> ctrl_bus_oe && port_bus_lines == ctrl_bus_out)
        else $error("address not driven alone on select");
    chk_write_drive: assert property (write_direction_strobe && master_clock
        |-> ctrl_bus_oe && port_bus_lines == ctrl_bus_out)
        else $error("data not driven alone on write");
    chk_read_release: assert property (master_clock && !address_select_strobe && !write_direction_strobe
        && !(left_bank_enable_n && right_bank_enable_n) |-> !ctrl_bus_oe)
        else $error("controller drives during read");
    chk_drive_span: assert property ($rose(ctrl_bus_oe) |-> ctrl_bus_oe [*3])
        else $error("bus drive shorter than three quarters");
    chk_strobe_stand: assert property (master_clock |-> $stable({address_select_strobe,
        write_direction_strobe, left_bank_enable_n, right_bank_enable_n}))
        else $error("strobes moved inside a cycle");
    chk_bank_strobe: assert property (address_select_strobe || write_direction_strobe
        |-> !(left_bank_enable_n && right_bank_enable_n))
        else $error("strobe without a bank");
    chk_reset_idle: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |-> left_bank_enable_n
        && right_bank_enable_n && !master_clock && !address_select_strobe && !ctrl_bus_oe)
        else $error("bus not idle in reset");
endmodule // psbp_bus_monitor
`default_nettype wire

// [tb/peripheral_select_bus_port_tb.sv]
// Self-checking bench: controller and two ports sharing one address
`timescale 1ns/1ns
`default_nettype none
module peripheral_select_bus_port_tb
    import psbp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic halt_n = 1'b1;
    logic [INSTR_W-1:0] instruction_lines = IR_RESET;
    logic [INSTR_W-1:0] prog [16];
    logic [BYTE_W-1:0] sup0, sup1, d1, d2, s, rd, tb0, tb1;
    logic [BYTE_W-1:0] q_sel[$], q_wr[$], q_t0[$], q_t1[$], q_rd[$];
    logic [PA_W-1:0] pa, pidx, pa_held;
    logic rv, tv0, tv1, sel0, sel1, halted, ss0, ss1;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_mclk = 0;
    int k;
    psbp_if bus_if();
    psbp_ctrl psbp_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .halt_n(halt_n), .program_address_lines(pa),
        .instruction_lines(instruction_lines), .read_data(rd), .read_valid(rv), .halted(halted), .bus(bus_if.ctrl));
    // Input port on the left, output port snooping on the right, same address
    psbp_port #(.PORT_ADDR(8'h5A))
        psbp_port_left_i (.sys_clk(sys_clk), .reset_n(reset_n), .supply_byte(sup0), .taken_byte(tb0),
        .taken_valid(tv0), .supply_served(ss0), .selected(sel0), .bus(bus_if.port));
    psbp_port #(.PORT_INDEX(1), .PORT_ADDR(8'h5A), .RIGHT_BANK(1'b1), .SNOOP_READS(1'b1))
        psbp_port_right_i (.sys_clk(sys_clk), .reset_n(reset_n), .supply_byte(sup1), .taken_byte(tb1),
        .taken_valid(tv1), .supply_served(ss1), .selected(sel1), .bus(bus_if.port));
    psbp_bus_monitor monitor_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .address_select_strobe(bus_if.address_select_strobe), .write_direction_strobe(bus_if.write_direction_strobe),
        .left_bank_enable_n(bus_if.left_bank_enable_n), .right_bank_enable_n(bus_if.right_bank_enable_n),
        .master_clock(bus_if.master_clock), .ctrl_bus_out(bus_if.ctrl_bus_out), .ctrl_bus_oe(bus_if.ctrl_bus_oe),
        .port_bus_lines(bus_if.port_bus_lines));

    // Wire level of a byte: reversed lines, low means one
    function automatic logic [BYTE_W-1:0] wire_of(input logic [BYTE_W-1:0] b);
        logic [BYTE_W-1:0] r;
        r = {<<{b}};
        return ~r;
    endfunction

    function automatic logic [INSTR_W-1:0] lines_of(input logic [INSTR_W-1:0] w);
        logic [INSTR_W-1:0] r;
        r = {<<{w}};
        return r;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    assign pidx = {<<{pa}};

    // Program store answers one edge late, well before the quarter-3 fetch
    always @(posedge sys_clk) begin
        instruction_lines <= lines_of((pidx < 13'h0010) ? prog[pidx[3:0]] : IR_RESET);
        cyc <= cyc + 1;
        if (bus_if.master_clock) n_mclk <= n_mclk + 1;
        if (bus_if.master_clock && bus_if.address_select_strobe)
            chk(bus_if.port_bus_lines, wire_of(q_sel.pop_front()));
        if (bus_if.master_clock && bus_if.write_direction_strobe)
            chk(bus_if.port_bus_lines, wire_of(q_wr.pop_front()));
        if (bus_if.master_clock && !bus_if.left_bank_enable_n && !bus_if.address_select_strobe
            && !bus_if.write_direction_strobe) chk(bus_if.port_bus_lines, wire_of(sup0));
        if (rv || ss0 || ss1) chk({rv, ss0, ss1}, 3'h6);
        if (rv) chk(rd, q_rd.pop_front());
        if (tv0) chk(tb0, q_t0.pop_front());
        if (tv1) chk(tb1, q_t1.pop_front());
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(97));
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        s = 8'($urandom);
        sup0 <= s;
        sup1 <= 8'($urandom);
        foreach (prog[i]) prog[i] = IR_RESET;
        prog[0] = {PSBP_SELECT, 2'h3, 4'h0, 8'h5A};
        prog[1] = {PSBP_WRITE, 2'h2, 4'h0, d1};
        prog[2] = {PSBP_READ, 2'h3, 4'h0, 8'h00};
        prog[3] = {PSBP_WRITE, 2'h1, 4'h0, d2};
        prog[4] = {PSBP_SELECT, 2'h2, 4'h0, 8'h33};
        q_sel = '{8'h5A, 8'h33};
        q_wr = '{d1, d2};
        q_t0 = '{d1};
        q_t1 = '{s, d2};
        q_rd = '{s};
        repeat (3) @(posedge sys_clk);
        chk(pa, PC_RESET);
        reset_n <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk(sel0, 1'b0);
        chk(sel1, 1'b1);
        chk(q_sel.size() + q_wr.size() + q_t0.size() + q_t1.size() + q_rd.size(), 0);
        halt_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        pa_held = pa;
        k = n_mclk;
        repeat (4) @(posedge sys_clk);
        chk(halted, 1'b1);
        chk(pa, pa_held);
        chk({bus_if.left_bank_enable_n, bus_if.right_bank_enable_n}, 2'h3);
        chk(n_mclk - k, 1);
        // Second reset while halted, so the program is not replayed
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(pa, PC_RESET);
        chk({sel0, sel1}, 2'h0);
        reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(pa, PC_RESET);
        end_sim();
    end
endmodule // peripheral_select_bus_port_tb
`default_nettype wire
